/* File: logic/mmts_slave.v */
// Purpose: Two-wire management slave with diagnostics readout and attention line.
// Assumes: Host is the only master; bus clock is far slower than mclk.
// Notes: Pin synchronisers reset high, the idle level of the bus and of module select.
`timescale 1ns/1ns
`include "mmts_defines.vh"
module mmts_slave
#(
    parameter NCHAN = 4
)
(
    input wire mclk,
    input wire rst_b,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    input wire module_select_n,
    output wire attention_out,
    output wire attention_oe,
    input wire [15:0] temp_val,
    input wire [15:0] vcc_val,
    input wire [NCHAN*16-1:0] bias_val,
    input wire [NCHAN*16-1:0] rxp_val,
    input wire [NCHAN*16-1:0] txp_val,
    input wire [NCHAN-1:0] chan_flag,
    input wire data_ready
);
localparam ST_IDLE = 6'h01;
localparam ST_ADDR = 6'h02;
localparam ST_ACK = 6'h04;
localparam ST_WR = 6'h08;
localparam ST_RD = 6'h10;
localparam ST_RACK = 6'h20;
localparam [7:0] MAP_BYTES = `MMTS_MAP_BYTES;
wire scl_s;
wire sda_s;
wire sel_s;
reg scl_d_r;
reg sda_d_r;
reg [5:0] st_r;
reg [3:0] bit_r;
reg [7:0] sh_r;
reg rw_r;
reg first_r;
reg [7:0] ptr_r;
reg drive_r;
reg ack_pend_r;
reg rd_stop_r;
reg dnr_seen_r;
reg flag_seen_r;
reg int_low_r;
reg [7:0] rbyte;
mmts_sync u_scl (.mclk(mclk), .rst_b(rst_b), .pin_in(scl_in), .pin_out(scl_s));
mmts_sync u_sda (.mclk(mclk), .rst_b(rst_b), .pin_in(sda_in), .pin_out(sda_s));
mmts_sync u_sel (.mclk(mclk), .rst_b(rst_b), .pin_in(module_select_n), .pin_out(sel_s));
// Channel offsets are worked out in 32 bits so that the parameter arithmetic loses nothing.
wire [31:0] chan_off = {24'h000000, ptr_r - `MMTS_ADDR_CHAN};
wire [31:0] bias_idx = chan_off >> 1;
wire [31:0] rxp_idx = (chan_off - NCHAN * 2) >> 1;
wire [31:0] txp_idx = (chan_off - NCHAN * 4) >> 1;
wire scl_rise = scl_s & ~scl_d_r;
wire scl_fall = ~scl_s & scl_d_r;
wire start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
wire stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
// Picks a byte of a 16-bit big-endian value for one channel.
function [7:0] pick;
    input [NCHAN*16-1:0] vec;
    input [7:0] idx;
    input hi;
    reg [15:0] w;
    begin
        w = vec[idx*16 +: 16];
        pick = hi ? w[15:8] : w[7:0];
    end
endfunction
// Map: status at 2, channel flags at 3, temperature 22-23, supply 26-27,
// then per channel bias, receive power and transmit power, two bytes each.
always @*
begin
    rbyte = 8'h00;
    if (ptr_r == `MMTS_ADDR_STATUS)
        rbyte = {7'h00, ~data_ready};
    else if (ptr_r == `MMTS_ADDR_FLAG_FIRST)
        rbyte = {{(8-NCHAN){1'b0}}, chan_flag};
    else if (ptr_r == `MMTS_ADDR_TEMP)
        rbyte = temp_val[15:8];
    else if (ptr_r == `MMTS_ADDR_TEMP + 8'h01)
        rbyte = temp_val[7:0];
    else if (ptr_r == `MMTS_ADDR_VCC)
        rbyte = vcc_val[15:8];
    else if (ptr_r == `MMTS_ADDR_VCC + 8'h01)
        rbyte = vcc_val[7:0];
    else if (ptr_r >= `MMTS_ADDR_CHAN && ptr_r < `MMTS_ADDR_CHAN + NCHAN * 6)
    begin
        if (chan_off < NCHAN * 2)
            rbyte = pick(bias_val, bias_idx[7:0], ~ptr_r[0]);
        else if (chan_off < NCHAN * 4)
            rbyte = pick(rxp_val, rxp_idx[7:0], ~ptr_r[0]);
        else
            rbyte = pick(txp_val, txp_idx[7:0], ~ptr_r[0]);
    end
end
always @(posedge mclk or negedge rst_b)
begin
    if (!rst_b)
    begin
        scl_d_r <= 1'b1;
        sda_d_r <= 1'b1;
        st_r <= ST_IDLE;
        bit_r <= 4'h0;
        sh_r <= 8'h00;
        rw_r <= 1'b0;
        first_r <= 1'b0;
        ptr_r <= 8'h00;
        drive_r <= 1'b0;
        ack_pend_r <= 1'b0;
        rd_stop_r <= 1'b0;
        dnr_seen_r <= 1'b0;
        flag_seen_r <= 1'b0;
        int_low_r <= 1'b1;
    end
    else
    begin
        scl_d_r <= scl_s;
        sda_d_r <= sda_s;
        if (dnr_seen_r && flag_seen_r)
            int_low_r <= 1'b0;
        if (start_c && !sel_s)
        begin
            st_r <= ST_ADDR;
            bit_r <= 4'h0;
            drive_r <= 1'b0;
        end
        else if (stop_c || sel_s)
        begin
            st_r <= ST_IDLE;
            drive_r <= 1'b0;
        end
        else
        begin
            case (st_r)
                ST_IDLE:
                    drive_r <= 1'b0;
                ST_ADDR, ST_WR:
                    if (scl_rise)
                    begin
                        sh_r <= {sh_r[6:0], sda_s};
                        bit_r <= bit_r + 4'h1;
                    end
                    else if (scl_fall && bit_r == 4'h8)
                    begin
                        bit_r <= 4'h0;
                        if (st_r == ST_ADDR)
                        begin
                            if (sh_r[7:1] == `MMTS_DEV_ADDR)
                            begin
                                rw_r <= sh_r[0];
                                first_r <= 1'b1;
                                drive_r <= 1'b1;
                                st_r <= ST_ACK;
                            end
                            else
                                st_r <= ST_IDLE;
                        end
                        else
                        begin
                            if (first_r)
                                ptr_r <= sh_r;
                            else
                                ptr_r <= ptr_r + 8'h01;
                            first_r <= 1'b0;
                            drive_r <= 1'b1;
                            st_r <= ST_ACK;
                        end
                    end
                ST_ACK:
                    if (scl_fall)
                    begin
                        if (rw_r)
                        begin
                            sh_r <= rbyte;
                            drive_r <= ~rbyte[7];
                            bit_r <= 4'h1;
                            if (ptr_r == `MMTS_ADDR_STATUS && rbyte[`MMTS_STATUS_DNR_BIT] == 1'b0)
                                dnr_seen_r <= 1'b1;
                            if (ptr_r >= `MMTS_ADDR_FLAG_FIRST && ptr_r <= `MMTS_ADDR_FLAG_LAST)
                                flag_seen_r <= 1'b1;
                            st_r <= ST_RD;
                        end
                        else
                        begin
                            drive_r <= 1'b0;
                            st_r <= ST_WR;
                        end
                    end
                ST_RD:
                    if (scl_fall)
                    begin
                        if (bit_r == 4'h8)
                        begin
                            drive_r <= 1'b0;
                            ptr_r <= (ptr_r + 8'h01 >= MAP_BYTES) ? 8'h00 : ptr_r + 8'h01;
                            st_r <= ST_RACK;
                        end
                        else
                        begin
                            drive_r <= ~sh_r[7 - bit_r[2:0]];
                            bit_r <= bit_r + 4'h1;
                        end
                    end
                ST_RACK:
                    if (scl_rise)
                        rd_stop_r <= sda_s;
                    else if (scl_fall)
                    begin
                        if (rd_stop_r)
                            st_r <= ST_IDLE;
                        else
                        begin
                            sh_r <= rbyte;
                            drive_r <= ~rbyte[7];
                            bit_r <= 4'h1;
                            if (ptr_r >= `MMTS_ADDR_FLAG_FIRST && ptr_r <= `MMTS_ADDR_FLAG_LAST)
                                flag_seen_r <= 1'b1;
                            if (ptr_r == `MMTS_ADDR_STATUS && rbyte[0] == 1'b0)
                                dnr_seen_r <= 1'b1;
                            st_r <= ST_RD;
                        end
                    end
                default:
                    st_r <= ST_IDLE;
            endcase
        end
    end
end
// The line is only ever pulled low; the host pull-up supplies the high level.
assign sda_out = 1'b0;
assign sda_oe = drive_r;
assign attention_out = 1'b0;
assign attention_oe = int_low_r;
endmodule

/* File: logic/mmts_defines.vh */
// Purpose: Shared constants for the module management two-wire slave.
// Assumes: Included by its bare name from the slave design file.
// Notes: Byte addresses of the small management map are fixed here.
`ifndef MMTS_DEFINES_VH
`define MMTS_DEFINES_VH
`define MMTS_DEV_ADDR 7'h50
`define MMTS_MAP_BYTES 8'h40
`define MMTS_ADDR_STATUS 8'h02
`define MMTS_STATUS_DNR_BIT 0
`define MMTS_ADDR_FLAG_FIRST 8'h03
`define MMTS_ADDR_FLAG_LAST 8'h15
`define MMTS_ADDR_TEMP 8'h16
`define MMTS_ADDR_VCC 8'h1a
`define MMTS_ADDR_CHAN 8'h22
`define MMTS_SYNC_STAGES 2
`endif

/* File: logic/mmts_sync.v */
// Purpose: Two-flop synchroniser for one pin level.
// Assumes: Input is asynchronous to mclk.
// Notes: Only the second stage is visible to the caller; both stages reset to the idle high.
`timescale 1ns/1ns
module mmts_sync
(
    input wire mclk,
    input wire rst_b,
    input wire pin_in,
    output reg pin_out
);
reg meta_r;
always @(posedge mclk or negedge rst_b)
begin
    if (!rst_b)
    begin
        meta_r <= 1'b1;
        pin_out <= 1'b1;
    end
    else
    begin
        meta_r <= pin_in;
        pin_out <= meta_r;
    end
end
endmodule

/* File: verif/mmts_checker.sv */
// Purpose: Port checker for the management two-wire slave.
// Assumes: A bus clock half period spans four mclk cycles.
// Notes: Bound to every mmts_slave instance.
`timescale 1ns/1ns
module mmts_checker
(
    input wire mclk,
    input wire rst_b,
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe,
    input wire module_select_n,
    input wire attention_out,
    input wire attention_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    // Eight high cycles of the bus clock only occur while the bus is idle.
    sequence s_idle;
        scl_in [*8];
    endsequence
    sequence s_desel;
        module_select_n [*5];
    endsequence
    sequence s_held;
        sda_oe [*5];
    endsequence
    AST_SDA_OPEN_DRAIN: assert property (sda_out == 1'b0)
        else $error("data pin drives high");
    AST_ATT_OPEN_DRAIN: assert property (attention_out == 1'b0)
        else $error("attention pin drives high");
    AST_CHANGE_CLK_LOW: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data changed with clock high");
    AST_NO_DRIVE_IDLE: assert property (s_idle |-> !sda_oe)
        else $error("data driven on idle bus");
    AST_DESELECT_QUIET: assert property (s_desel |-> !sda_oe)
        else $error("data driven while deselected");
    AST_DRIVE_HELD: assert property ($rose(sda_oe) |-> s_held)
        else $error("data low not held over clock high");
    AST_ATT_STAYS: assert property (!attention_oe |=> !attention_oe)
        else $error("attention pulled low again");
    AST_ATT_ON_READ: assert property ($fell(attention_oe) |-> !module_select_n)
        else $error("attention released outside a read");
endmodule
bind mmts_slave mmts_checker u_chk (.mclk(mclk), .rst_b(rst_b), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .module_select_n(module_select_n),
    .attention_out(attention_out), .attention_oe(attention_oe));

/* File: verif/mmts_host.sv */
// Purpose: Host master model driving the two-wire bus.
// Assumes: Bus clock period is eight mclk cycles.
// Notes: Released data line floats to the pull-up level.
`timescale 1ns/1ns
module mmts_host
(
    input wire mclk,
    input wire sda,
    output logic scl = 1'b1,
    output logic sda_low = 1'b0
);
    task automatic w2();
        repeat (2) @(posedge mclk);
    endtask
    // The clock rises only after any slave acknowledge is released.
    task automatic st();
        sda_low <= 1'b0;
        w2();
        scl <= 1'b1;
        w2();
        sda_low <= 1'b1;
        w2();
        scl <= 1'b0;
        w2();
    endtask
    task automatic sp();
        sda_low <= 1'b1;
        w2();
        scl <= 1'b1;
        w2();
        sda_low <= 1'b0;
        w2();
        w2();
    endtask
    task automatic bt(input logic b, output logic r);
        sda_low <= !b;
        w2();
        scl <= 1'b1;
        w2();
        r = sda;
        w2();
        scl <= 1'b0;
        w2();
    endtask
    task automatic xb(input logic [7:0] d, input logic am, output logic [7:0] q,
        output logic ar);
        integer i;
        for (i = 7; i >= 0; i--)
            bt(d[i], q[i]);
        bt(am, ar);
    endtask
endmodule

/* File: verif/tb_module_mgmt_twowire_slave.sv */
// Purpose: Self-checking bench for the management two-wire slave.
// Assumes: Channel count of four.
// Notes: Bytes 34 onward hold bias, receive and transmit pairs.
`timescale 1ns/1ns
module tb_module_mgmt_twowire_slave;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic module_select_n = 1'b0;
    logic data_ready = 1'b0;
    logic [15:0] temp_val = 16'h0000;
    logic [15:0] vcc_val = 16'h0000;
    logic [63:0] bias_val = 64'h0;
    logic [63:0] rxp_val = 64'h0;
    logic [63:0] txp_val = 64'h0;
    logic [3:0] chan_flag = 4'h0;
    logic scl, h_low, sda_out, sda_oe, attention_out, attention_oe;
    wire sda = (sda_oe ? sda_out : 1'b1) & !h_low;
    wire attention_out_n = attention_oe ? attention_out : 1'b1;
    integer errors = 0;
    integer n_tests = 0;
    integer cyc = 0;
    integer seed = 32'h15c5;
    mmts_slave #(.NCHAN(4)) u_dut (.mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .module_select_n(module_select_n),
        .attention_out(attention_out), .attention_oe(attention_oe), .temp_val(temp_val),
        .vcc_val(vcc_val), .bias_val(bias_val), .rxp_val(rxp_val), .txp_val(txp_val),
        .chan_flag(chan_flag), .data_ready(data_ready));
    mmts_host u_host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(h_low));
    initial forever #25 mclk = ~mclk;
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors = errors + 1;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        n_tests = n_tests + 1;
        if (s !== e)
        begin
            errors = errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic logic [7:0] xp(input integer a);
        logic [15:0] w;
        w = 16'h0000;
        if (a >= 34 && a < 58)
            w = 16'({txp_val, rxp_val, bias_val} >> ((a - 34) / 2 * 16));
        if (a == 22 || a == 23)
            w = temp_val;
        if (a == 26 || a == 27)
            w = vcc_val;
        xp = (a % 2) ? w[7:0] : w[15:8];
        if (a == 2)
            xp = {7'h00, !data_ready};
        if (a == 3)
            xp = {4'h0, chan_flag};
    endfunction
    // Pointer write, one ignored data byte, then a read from the next byte.
    task automatic tr(input logic [6:0] ad, input logic [7:0] p, input integer n,
        input logic ea);
        logic [7:0] q;
        logic a;
        integer k;
        u_host.st();
        u_host.xb({ad, 1'b0}, 1'b1, q, a);
        chk("address ack", 8'(a), 8'(!ea));
        if (ea)
        begin
            u_host.xb(p, 1'b1, q, a);
            u_host.xb(8'h5a, 1'b1, q, a);
            chk("write ack", 8'(a), 8'h00);
            u_host.st();
            u_host.xb({ad, 1'b1}, 1'b1, q, a);
            for (k = 1; k <= n; k++)
            begin
                u_host.xb(8'hff, k == n, q, a);
                chk("read byte", q, xp(p + k));
            end
        end
        u_host.sp();
    endtask
    initial
    begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("attention", 8'(attention_out_n), 8'h00);
        tr(7'h50, 8'h01, 2, 1'b1);
        chk("attention", 8'(attention_out_n), 8'h00);
        data_ready <= 1'b1;
        temp_val <= 16'($random(seed));
        vcc_val <= 16'($random(seed));
        chan_flag <= 4'($random(seed));
        bias_val <= {$random(seed), $random(seed)};
        rxp_val <= {$random(seed), $random(seed)};
        txp_val <= {$random(seed), $random(seed)};
        tr(7'h50, 8'h01, 2, 1'b1);
        repeat (4) @(posedge mclk);
        chk("attention", 8'(attention_out_n), 8'h01);
        // A second reset pulls attention low again; status alone must not release it.
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("attention", 8'(attention_out_n), 8'h00);
        tr(7'h50, 8'h01, 1, 1'b1);
        repeat (4) @(posedge mclk);
        chk("attention", 8'(attention_out_n), 8'h00);
        tr(7'h50, 8'h02, 1, 1'b1);
        repeat (4) @(posedge mclk);
        chk("attention", 8'(attention_out_n), 8'h01);
        tr(7'h50, 8'h15, 2, 1'b1);
        tr(7'h50, 8'h19, 2, 1'b1);
        tr(7'h50, 8'h21, 24, 1'b1);
        tr(7'h51, 8'h00, 0, 1'b0);
        module_select_n <= 1'b1;
        repeat (4) @(posedge mclk);
        tr(7'h50, 8'h00, 0, 1'b0);
        complete_run();
    end
endmodule
